// ==== bench/rtcu_unit_bench.sv ====
// Purpose: self-checking bench of the rotate-through-carry unit
// Assumes: results show just after the edge that takes an instruction
// Notes: inputs change at the rising edge by non-blocking assignment
`timescale 1ns/1ns
`default_nettype none
module rtcu_unit_bench import rtcu_pkg::*;;
   logic clock = 1'b0;
   logic reset = 1'b1;
   logic instr_valid = 1'b0;
   rtcu_instr_t instr = '0;
   logic load_valid = 1'b0;
   logic [6:0] load_addr = 7'h00;
   logic [7:0] load_data = 8'h00;
   logic [6:0] peek_addr = 7'h00;
   logic [7:0] peek_data;
   logic [7:0] acc;
   logic [2:0] status;
   logic done;
   int miscompares = 0;
   int checks_done = 0;
   rtcu_unit rtcu_unit_i (.clock(clock), .reset(reset), .instr_valid(instr_valid), .instr(instr),
      .load_valid(load_valid), .load_addr(load_addr), .load_data(load_data), .peek_addr(peek_addr),
      .peek_data(peek_data), .acc(acc), .status(status), .done(done));
   initial
   begin
      forever #10 clock = ~clock;
   end
   task tally_and_finish;
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task see(input logic [7:0] a_exp, input logic [7:0] f_exp, input logic [2:0] s_exp, input logic d_exp);
      chk("acc", acc, a_exp);
      chk("file", peek_data, f_exp);
      chk("status", {5'h00, status}, {5'h00, s_exp});
      chk("done", {7'h00, done}, {7'h00, d_exp});
   endtask
   task ld(input logic [6:0] a, input logic [7:0] d);
      @(posedge clock);
      load_valid <= 1'b1;
      load_addr <= a;
      load_data <= d;
      peek_addr <= a;
   endtask
   task exec(input rtcu_op_t o, input logic [6:0] a, input logic d);
      @(posedge clock);
      load_valid <= 1'b0;
      instr_valid <= 1'b1;
      instr <= '{o, a, d};
   endtask
   task idle;
      @(posedge clock);
      load_valid <= 1'b0;
      instr_valid <= 1'b0;
      #1;
   endtask
   // --------------------------------------------------
   // scenarios
   // --------------------------------------------------
   task t_left_acc;
      ld(7'h05, 8'hE6);
      exec(rotate_left_carry_op, 7'h05, 1'b0);
      idle;
      see(8'hCC, 8'hE6, 3'h1, 1'b1);
      idle;
      chk("done_drop", {7'h00, done}, 8'h00);
      $display("test left_acc finished");
   endtask
   task t_left_file;
      ld(7'h00, 8'h80);
      exec(rotate_left_carry_op, 7'h00, 1'b1);
      exec(rotate_left_carry_op, 7'h00, 1'b0);
      #1;
      see(8'hCC, 8'h01, 3'h1, 1'b1);
      idle;
      see(8'h03, 8'h01, 3'h0, 1'b1);
      $display("test left_file finished");
   endtask
   task t_right;
      ld(7'h7F, 8'h81);
      exec(rotate_right_carry_op, 7'h7F, 1'b1);
      exec(rotate_right_carry_op, 7'h7F, 1'b1);
      #1;
      see(8'h03, 8'h40, 3'h1, 1'b1);
      exec(rotate_right_carry_op, 7'h7F, 1'b0);
      #1;
      see(8'h03, 8'hA0, 3'h0, 1'b1);
      idle;
      see(8'h50, 8'hA0, 3'h0, 1'b1);
      $display("test right finished");
   endtask
   task t_none;
      exec(rtcu_op_none, 7'h7F, 1'b1);
      idle;
      see(8'h50, 8'hA0, 3'h0, 1'b0);
      @(posedge clock);
      instr_valid <= 1'b1;
      instr <= rtcu_instr_t'({2'b11, 7'h7F, 1'b0});
      idle;
      see(8'h50, 8'hA0, 3'h0, 1'b0);
      $display("test none finished");
   endtask
   initial
   begin
      repeat (6) @(posedge clock);
      reset <= 1'b0;
      t_left_acc;
      t_left_file;
      t_right;
      t_none;
      tally_and_finish;
   end
   initial
   begin
      repeat (500) @(posedge clock);
      miscompares++;
      tally_and_finish;
   end
endmodule // rtcu_unit_bench
`default_nettype wire

// ==== core/rtcu_consts.svh ====
// Purpose: constants of the rotate-through-carry unit
// Assumes: 8-bit data, 7-bit file register address
// Notes: macros only, types live in the package
`ifndef RTCU_CONSTS_SVH
`define RTCU_CONSTS_SVH
`define RTCU_DATA_W 8
`define RTCU_ADDR_W 7
`define RTCU_FILE_DEPTH 128
`define RTCU_DEST_ACC 1'b0
`define RTCU_DEST_FILE 1'b1
`define RTCU_ACC_RESET 8'h00
`define RTCU_FILE_RESET 8'h00
`define RTCU_STATUS_RESET 3'h0
`define RTCU_STATUS_CARRY 0
`define RTCU_STATUS_DIGIT 1
`define RTCU_STATUS_ZERO 2
`endif

// ==== core/rtcu_pkg.sv ====
// Purpose: types of the rotate-through-carry unit
// Assumes: constants header in the include path
// Notes: none
`include "rtcu_consts.svh"
package rtcu_pkg;
   typedef enum logic [1:0] {rtcu_op_none, rotate_left_carry_op, rotate_right_carry_op} rtcu_op_t;
   typedef struct packed {
      rtcu_op_t op;
      logic [`RTCU_ADDR_W-1:0] addr;
      logic dest;
   } rtcu_instr_t;
   typedef struct packed {
      logic [`RTCU_DATA_W-1:0] value;
      logic carry;
   } rtcu_result_t;
endpackage

// ==== core/rtcu_rotator.sv ====
// Purpose: combinational rotate of one byte through carry
// Assumes: op from the decoder
// Notes: non-rotate ops pass operand and carry through
`timescale 1ns/1ns
`default_nettype none
`include "rtcu_consts.svh"
module rtcu_rotator
   import rtcu_pkg::*;
(
   input wire rtcu_op_t op, // operation
   input wire logic [`RTCU_DATA_W-1:0] operand, // file register value
   input wire logic carry_in, // current carry
   output var rtcu_result_t result // rotated value and new carry
);
   always_comb
   begin
      case (op)
         rotate_left_carry_op: result = '{value: {operand[`RTCU_DATA_W-2:0], carry_in},
                                          carry: operand[`RTCU_DATA_W-1]};
         rotate_right_carry_op: result = '{value: {carry_in, operand[`RTCU_DATA_W-1:1]},
                                           carry: operand[0]};
         default: result = '{value: operand, carry: carry_in};
      endcase
   end
endmodule // rtcu_rotator
`default_nettype wire

// ==== core/rtcu_unit.sv ====
// Purpose: rotate-through-carry datapath with file registers, accumulator and status
// Assumes: instr valid for one cycle per instruction, same clock as the decoder
// Notes: one instruction per clock; a write port loads file registers from outside
`timescale 1ns/1ns
`default_nettype none
`include "rtcu_consts.svh"
module rtcu_unit
   import rtcu_pkg::*;
(
   input wire logic clock, // 50 MHz instruction clock
   input wire logic reset, // async, active high
   input wire logic instr_valid, // instruction present this cycle
   input wire rtcu_instr_t instr, // decoded instruction
   input wire logic load_valid, // direct file register load
   input wire logic [`RTCU_ADDR_W-1:0] load_addr, // load address
   input wire logic [`RTCU_DATA_W-1:0] load_data, // load data
   input wire logic [`RTCU_ADDR_W-1:0] peek_addr, // file register read address
   output logic [`RTCU_DATA_W-1:0] peek_data, // registered file value
   output logic [`RTCU_DATA_W-1:0] acc, // working accumulator
   output logic [2:0] status, // zero, digit carry, carry
   output logic done // pulse one cycle after a rotate
);
   // ----------------------------------------
   // state
   // ----------------------------------------
   logic [`RTCU_DATA_W-1:0] file_q [`RTCU_FILE_DEPTH];
   logic [`RTCU_DATA_W-1:0] file_d [`RTCU_FILE_DEPTH];
   logic [`RTCU_DATA_W-1:0] acc_q, acc_d, peek_q, peek_d;
   logic [2:0] status_q, status_d;
   logic done_q, done_d;
   rtcu_result_t res;
   logic rot;

   rtcu_rotator u_rot (
      .op(instr.op),
      .operand(file_q[instr.addr]),
      .carry_in(status_q[`RTCU_STATUS_CARRY]),
      .result(res)
   );

   // ----------------------------------------
   // decode
   // ----------------------------------------
   // only the two rotate codes act; none and any stray code are refused
   function automatic logic is_rotate(input rtcu_op_t op);
      return (op == rotate_left_carry_op) || (op == rotate_right_carry_op);
   endfunction

   assign rot = instr_valid && is_rotate(instr.op);

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb
   begin
      file_d = file_q;
      acc_d = acc_q;
      status_d = status_q;
      done_d = rot;
      if (load_valid)
      begin
         file_d[load_addr] = load_data;
      end
      if (rot)
      begin
         status_d[`RTCU_STATUS_CARRY] = res.carry;
         if (instr.dest == `RTCU_DEST_ACC)
         begin
            acc_d = res.value;
         end
         else
         begin
            file_d[instr.addr] = res.value;
         end
      end
      peek_d = file_d[peek_addr];
   end

   always_ff @(posedge clock or posedge reset)
   begin
      if (reset)
      begin
         for (int i = 0; i < `RTCU_FILE_DEPTH; i++)
         begin
            file_q[i] <= `RTCU_FILE_RESET;
         end
         acc_q <= `RTCU_ACC_RESET;
         status_q <= `RTCU_STATUS_RESET;
         peek_q <= `RTCU_FILE_RESET;
         done_q <= 1'b0;
      end
      else
      begin
         file_q <= file_d;
         acc_q <= acc_d;
         status_q <= status_d;
         peek_q <= peek_d;
         done_q <= done_d;
      end
   end

   assign peek_data = peek_q;
   assign acc = acc_q;
   assign status = status_q;
   assign done = done_q;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (reset);

   // ----------------------------------------
   // value checks
   // ----------------------------------------
   rotl_value_a: assert property (
      rot && instr.op == rotate_left_carry_op && instr.dest == `RTCU_DEST_ACC
      |=> acc_q == {$past(file_q[instr.addr][6:0]), $past(status_q[0])}
         && status_q[0] == $past(file_q[instr.addr][7]))
      else $error("left rotate wrong");

   rotr_value_a: assert property (
      rot && instr.op == rotate_right_carry_op && instr.dest == `RTCU_DEST_ACC
      |=> acc_q == {$past(status_q[0]), $past(file_q[instr.addr][7:1])}
         && status_q[0] == $past(file_q[instr.addr][0]))
      else $error("right rotate wrong");

   rotl_file_a: assert property (
      rot && instr.op == rotate_left_carry_op && instr.dest == `RTCU_DEST_FILE
      |=> file_q[$past(instr.addr)] == {$past(file_q[instr.addr][6:0]), $past(status_q[0])}
         && status_q[0] == $past(file_q[instr.addr][7]))
      else $error("left rotate write back wrong");

   rotr_file_a: assert property (
      rot && instr.op == rotate_right_carry_op && instr.dest == `RTCU_DEST_FILE
      |=> file_q[$past(instr.addr)] == {$past(status_q[0]), $past(file_q[instr.addr][7:1])}
         && status_q[0] == $past(file_q[instr.addr][0]))
      else $error("right rotate write back wrong");

   // ----------------------------------------
   // storage checks
   // ----------------------------------------
   acc_dest_a: assert property (
      rot && instr.dest == `RTCU_DEST_ACC && !(load_valid && load_addr == instr.addr)
      |=> file_q[$past(instr.addr)] == $past(file_q[instr.addr]))
      else $error("file changed on accumulator destination");

   file_dest_a: assert property (
      rot && instr.dest == `RTCU_DEST_FILE
      |=> file_q[$past(instr.addr)] == $past(res.value) && $stable(acc_q))
      else $error("file write back wrong");

   addr_range_a: assert property (
      rot |-> instr.addr <= 7'h7F)
      else $error("address out of range");

   load_write_a: assert property (
      load_valid && !(rot && instr.dest == `RTCU_DEST_FILE && instr.addr == load_addr)
      |=> file_q[$past(load_addr)] == $past(load_data))
      else $error("file load lost");

   peek_read_a: assert property (
      !load_valid && !rot ##1 !load_valid |-> peek_q == file_q[$past(peek_addr)])
      else $error("peek data wrong");

   peek_load_a: assert property (
      load_valid && peek_addr == load_addr
         && !(rot && instr.dest == `RTCU_DEST_FILE && instr.addr == load_addr)
      |=> peek_q == $past(load_data))
      else $error("peek misses same edge load");

   // ----------------------------------------
   // status and timing checks
   // ----------------------------------------
   flags_kept_a: assert property (
      rot |=> status_q[2:1] == $past(status_q[2:1]) && done_q)
      else $error("other flags changed");

   idle_stable_a: assert property (
      !rot |=> $stable(acc_q) && $stable(status_q) && !done_q)
      else $error("state changed without rotate");

   odd_op_a: assert property (
      instr_valid && !is_rotate(instr.op)
      |=> $stable(acc_q) && $stable(status_q) && !done_q)
      else $error("refused op changed state");

   done_source_a: assert property (
      done_q |-> $past(rot))
      else $error("done without rotate");

   // ----------------------------------------
   // coverage
   // ----------------------------------------
   left_acc_c: cover property (rot && instr.op == rotate_left_carry_op && instr.dest == `RTCU_DEST_ACC);
   right_file_c: cover property (rot && instr.op == rotate_right_carry_op && instr.dest == `RTCU_DEST_FILE);
   back_to_back_c: cover property (rot ##1 rot);
   load_clash_c: cover property (rot && instr.dest == `RTCU_DEST_FILE && load_valid && load_addr == instr.addr);
   odd_op_c: cover property (instr_valid && !is_rotate(instr.op));
endmodule // rtcu_unit
`default_nettype wire
